/* vps_defs.vh */
// register indices, field positions and reset values for the v-sequence block
`ifndef VPS_DEFS_VH
`define VPS_DEFS_VH

// register indices (byte address = 4 * index)
`define VPS_IDX_LOW_ASSIGN 5'h00
`define VPS_IDX_POLARITY 5'h01
`define VPS_IDX_FINAL_REP 5'h02
`define VPS_IDX_STATUS 5'h03
`define VPS_IDX_UP_ASSIGN 5'h08
`define VPS_IDX_PAT_SEL 5'h09
`define VPS_IDX_A_START 5'h0a
`define VPS_IDX_A_REP12 5'h0b
`define VPS_IDX_A_REP34 5'h0c
`define VPS_IDX_B_START 5'h0d
`define VPS_IDX_B_REP 5'h0e
`define VPS_IDX_C_START 5'h0f
`define VPS_IDX_C_REP 5'h10
`define VPS_IDX_D_START 5'h11
`define VPS_IDX_D_REP 5'h12
`define VPS_IDX_HOLD 5'h13
`define VPS_NUM_REGS 20

// field positions
`define VPS_LO_MSB 12
`define VPS_HI_LSB 13
`define VPS_HI_MSB 25
`define VPS_SEL_INC_BIT 20
`define VPS_SEL_RST_BIT 21
`define VPS_FINAL_EN_BIT 0

// widths and reset values
`define VPS_REG_W 26
`define VPS_POS_MAX 13'h1fff
`define VPS_REG_RESET 26'h0000000
`define VPS_SEQ_RESET 5'h00

`endif

/* vps_group_engine.v */
// one group's repetition engine: start, span, repeat count and freeze stall
`timescale 1ns/10ps
`default_nettype none

module vps_group_engine (
	input wire pclk, // pixel rate clock
	input wire presetn, // asynchronous reset, active low
	input wire line_start, // one-cycle pulse at start of line
	input wire run_en, // low while outputs are frozen
	input wire [12:0] pos, // pixel position in the line
	input wire [12:0] start_pos, // where the pattern begins
	input wire [12:0] span, // length of one repetition
	input wire [12:0] span_last, // length of the last repetition
	input wire last_en, // use span_last on last repetition
	input wire [12:0] reps, // number of repetitions
	output reg busy, // pattern is playing
	output reg [12:0] phase // position inside current repetition
);

	reg done;
	reg [12:0] rep;
	wire [12:0] cur_span;

	// last repetition may use its own span
	assign cur_span = (last_en && (rep == reps - 13'h0001)) ? span_last : span;

	// ----------------------------------------
	// repetition sequencing
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
			done <= 1'b0;
			phase <= 13'h0000;
			rep <= 13'h0000;
		end else if (line_start) begin
			busy <= 1'b0;
			done <= 1'b0;
			phase <= 13'h0000;
			rep <= 13'h0000;
		end else if (run_en) begin
			if (!busy && !done && pos == start_pos && reps != 13'h0000) begin
				busy <= 1'b1;
				phase <= 13'h0000;
				rep <= 13'h0000;
			end else if (busy) begin
				if (phase + 13'h0001 >= cur_span) begin
					phase <= 13'h0000;
					if (rep + 13'h0001 >= reps) begin
						busy <= 1'b0;
						done <= 1'b1;
					end else begin
						rep <= rep + 13'h0001;
					end
				end else begin
					phase <= phase + 13'h0001;
				end
			end
		end
	end

endmodule

`default_nettype wire

/* vps_seq_regs.v */
// v-sequence register file with APB slave, group engines and v-output drive
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "vps_defs.vh"

module vps_seq_regs (
	input wire pclk, // pixel rate clock, 100 MHz
	input wire presetn, // asynchronous reset, active low
	input wire psel, // apb select
	input wire penable, // apb access phase
	input wire pwrite, // apb direction, high for write
	input wire [7:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error on unmapped address
	input wire line_start, // one-cycle pulse, start of each line
	input wire seq_change, // one-cycle pulse, sequence change point
	input wire [4:0] region_seq, // sequence number of current region
	input wire [3:0] pattern_level, // stored pattern level per group
	output reg [23:0] v_out, // vertical outputs to the driver
	output reg [4:0] seq_num, // active sequence number
	output reg [19:0] pattern_pick, // pattern index per group, A low
	output reg [51:0] pattern_phase, // phase per group, A low
	output reg [3:0] group_busy, // group is playing its pattern
	output reg frozen // outputs are held
);

	// ----------------------------------------
	// storage and helpers
	// ----------------------------------------
	reg [25:0] stage [0:`VPS_NUM_REGS-1]; // software copy
	reg [25:0] act [0:`VPS_NUM_REGS-1]; // copy in use
	reg [12:0] pos;
	reg [1:0] line_idx;
	reg [25:0] rd_val;
	wire [4:0] idx;
	wire setup;
	wire access;
	wire [3:0] busy_w;
	wire [51:0] phase_w;
	wire [51:0] reps_w;
	wire [12:0] rep_a;
	wire odd_line;
	wire [47:0] assign_all;
	integer i;

	// writable bit mask of a register index, zero when unmapped
	function [25:0] reg_mask;
		input [4:0] k;
		begin
			case (k)
				`VPS_IDX_LOW_ASSIGN, `VPS_IDX_POLARITY,
				`VPS_IDX_UP_ASSIGN: reg_mask = 26'h0ffffff;
				`VPS_IDX_PAT_SEL: reg_mask = 26'h03fffff;
				`VPS_IDX_FINAL_REP: reg_mask = 26'h3ffe001;
				`VPS_IDX_A_START, `VPS_IDX_A_REP12, `VPS_IDX_A_REP34,
				`VPS_IDX_B_START, `VPS_IDX_B_REP, `VPS_IDX_C_START,
				`VPS_IDX_C_REP, `VPS_IDX_D_START, `VPS_IDX_D_REP,
				`VPS_IDX_HOLD: reg_mask = 26'h3ffffff;
				default: reg_mask = 26'h0000000;
			endcase
		end
	endfunction

	// true for any index that answers without error
	function mapped;
		input [4:0] k;
		begin
			mapped = (reg_mask(k) != 26'h0000000) || (k == `VPS_IDX_STATUS);
		end
	endfunction

	// low 13-bit field of a word
	function [12:0] lo13;
		input [25:0] w;
		begin
			lo13 = w[`VPS_LO_MSB:0];
		end
	endfunction

	// high 13-bit field of a word
	function [12:0] hi13;
		input [25:0] w;
		begin
			hi13 = w[`VPS_HI_MSB:`VPS_HI_LSB];
		end
	endfunction

	assign idx = paddr[6:2];
	assign setup = psel && !penable;
	assign access = psel && penable && pready;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// status word shows the block's own state
	always @* begin
		if (idx == `VPS_IDX_STATUS) begin
			rd_val = {14'h0000, line_idx, frozen, group_busy, seq_num};
		end else begin
			rd_val = stage[idx] & reg_mask(idx);
		end
	end

	// answer one cycle after setup; upper address bits must be zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (setup) begin
			pready <= 1'b1;
			pslverr <= !mapped(idx) || paddr[7] || (paddr[1:0] != 2'h0);
			prdata <= pwrite ? 32'h00000000 : {6'h00, rd_val};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// software writes land in the staging copy
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < `VPS_NUM_REGS; i = i + 1) begin
				stage[i] <= `VPS_REG_RESET;
			end
		end else if (access && pwrite && !pslverr) begin
			stage[idx] <= pwdata[25:0] & reg_mask(idx);
		end
	end

	// ----------------------------------------
	// sequence change transfer
	// ----------------------------------------
	// copy at change point
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < `VPS_NUM_REGS; i = i + 1) begin
				act[i] <= `VPS_REG_RESET;
			end
		end else if (seq_change) begin
			for (i = 0; i < `VPS_NUM_REGS; i = i + 1) begin
				act[i] <= stage[i];
			end
		end
	end

	// ----------------------------------------
	// line position and line index
	// ----------------------------------------
	// pixel position count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos <= 13'h0000;
		end else if (line_start) begin
			pos <= 13'h0000;
		end else if (pos != `VPS_POS_MAX) begin
			pos <= pos + 13'h0001;
		end
	end

	// change point parks the index so the next line start gives line one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_idx <= 2'h0;
		end else if (seq_change) begin
			line_idx <= 2'h3;
		end else if (line_start) begin
			line_idx <= line_idx + 2'h1;
		end
	end

	assign odd_line = !line_idx[0];

	// ----------------------------------------
	// sequence number
	// ----------------------------------------
	// restore takes priority over increment when both are set
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_num <= `VPS_SEQ_RESET;
		end else if (line_start) begin
			if (act[`VPS_IDX_PAT_SEL][`VPS_SEL_RST_BIT]) begin
				seq_num <= region_seq;
			end else if (act[`VPS_IDX_PAT_SEL][`VPS_SEL_INC_BIT]) begin
				seq_num <= seq_num + 5'h01;
			end
		end
	end

	// ----------------------------------------
	// hold and release
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frozen <= 1'b0;
		end else if (line_start) begin
			frozen <= 1'b0;
		end else if (!frozen && pos == lo13(act[`VPS_IDX_HOLD])) begin
			frozen <= 1'b1;
		end else if (frozen && pos == hi13(act[`VPS_IDX_HOLD])) begin
			frozen <= 1'b0;
		end
	end

	// ----------------------------------------
	// repeat count selection
	// ----------------------------------------
	// group A by line index
	assign rep_a = (line_idx == 2'h0) ? lo13(act[`VPS_IDX_A_REP12]) :
		(line_idx == 2'h1) ? hi13(act[`VPS_IDX_A_REP12]) :
		(line_idx == 2'h2) ? lo13(act[`VPS_IDX_A_REP34]) :
		hi13(act[`VPS_IDX_A_REP34]);

	assign reps_w[12:0] = rep_a;
	assign reps_w[25:13] = odd_line ? lo13(act[`VPS_IDX_B_REP]) :
		hi13(act[`VPS_IDX_B_REP]);
	assign reps_w[38:26] = odd_line ? lo13(act[`VPS_IDX_C_REP]) :
		hi13(act[`VPS_IDX_C_REP]);
	assign reps_w[51:39] = odd_line ? lo13(act[`VPS_IDX_D_REP]) :
		hi13(act[`VPS_IDX_D_REP]);

	// ----------------------------------------
	// group engines
	// ----------------------------------------
	// per-group start and span
	vps_group_engine u_grp_a (
		.pclk(pclk),
		.presetn(presetn),
		.line_start(line_start),
		.run_en(!frozen),
		.pos(pos),
		.start_pos(lo13(act[`VPS_IDX_A_START])),
		.span(hi13(act[`VPS_IDX_A_START])),
		.span_last(hi13(act[`VPS_IDX_A_START])),
		.last_en(1'b0),
		.reps(reps_w[12:0]),
		.busy(busy_w[0]),
		.phase(phase_w[12:0])
	);

	vps_group_engine u_grp_b (
		.pclk(pclk),
		.presetn(presetn),
		.line_start(line_start),
		.run_en(!frozen),
		.pos(pos),
		.start_pos(lo13(act[`VPS_IDX_B_START])),
		.span(hi13(act[`VPS_IDX_B_START])),
		.span_last(hi13(act[`VPS_IDX_B_START])),
		.last_en(1'b0),
		.reps(reps_w[25:13]),
		.busy(busy_w[1]),
		.phase(phase_w[25:13])
	);

	vps_group_engine u_grp_c (
		.pclk(pclk),
		.presetn(presetn),
		.line_start(line_start),
		.run_en(!frozen),
		.pos(pos),
		.start_pos(lo13(act[`VPS_IDX_C_START])),
		.span(hi13(act[`VPS_IDX_C_START])),
		.span_last(hi13(act[`VPS_IDX_C_START])),
		.last_en(1'b0),
		.reps(reps_w[38:26]),
		.busy(busy_w[2]),
		.phase(phase_w[38:26])
	);

	// group D may end on a separately programmed final span
	// software keeps final span equal
	vps_group_engine u_grp_d (
		.pclk(pclk),
		.presetn(presetn),
		.line_start(line_start),
		.run_en(!frozen),
		.pos(pos),
		.start_pos(lo13(act[`VPS_IDX_D_START])),
		.span(hi13(act[`VPS_IDX_D_START])),
		.span_last(hi13(act[`VPS_IDX_FINAL_REP])),
		.last_en(act[`VPS_IDX_FINAL_REP][`VPS_FINAL_EN_BIT]),
		.reps(reps_w[51:39]),
		.busy(busy_w[3]),
		.phase(phase_w[51:39])
	);

	// ----------------------------------------
	// pattern lookup and status outputs
	// ----------------------------------------
	// pattern index per group
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pattern_pick <= 20'h00000;
			pattern_phase <= 52'h0000000000000;
			group_busy <= 4'h0;
		end else begin
			pattern_pick <= act[`VPS_IDX_PAT_SEL][19:0];
			pattern_phase <= phase_w;
			group_busy <= busy_w;
		end
	end

	// ----------------------------------------
	// vertical output drive
	// ----------------------------------------
	// lower then upper assignment fields
	assign assign_all = {act[`VPS_IDX_UP_ASSIGN][23:0],
		act[`VPS_IDX_LOW_ASSIGN][23:0]};

	// level is polarity, flipped while the group's pattern says so
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			v_out <= 24'h000000;
		end else if (line_start) begin
			v_out <= act[`VPS_IDX_POLARITY][23:0];
		end else if (!frozen) begin
			for (i = 0; i < 24; i = i + 1) begin
				v_out[i] <= act[`VPS_IDX_POLARITY][i] ^
					(group_busy[assign_all[2*i +: 2]] &
					pattern_level[assign_all[2*i +: 2]]);
			end
		end
	end

endmodule

`default_nettype wire

/* vps_seq_regs_assertions.sv */
// port assertions for the v-sequence register block
`timescale 1ns/10ps
`default_nettype none
module vps_seq_regs_assertions (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic line_start, // line pulse
	input wire logic seq_change, // change pulse
	input wire logic [23:0] v_out, // v outputs
	input wire logic [4:0] seq_num, // sequence number
	input wire logic [19:0] pattern_pick, // picks
	input wire logic [51:0] pattern_phase, // phases
	input wire logic [3:0] group_busy, // busy flags
	input wire logic frozen // hold flag
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// bus handshake
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready too long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_err_upper: assert property (psel && !penable && paddr[7] |=> pslverr)
		else $error("upper address not refused");
	chk_rd_upper: assert property (pready && !pwrite |-> prdata[31:26] == 6'h00)
		else $error("unused read bits set");
	// sequence and output behaviour
	chk_seq_steady: assert property (
		!line_start |=> $stable(seq_num)) else $error("sequence moved");
	// pick is registered from the active copy, one stage behind it
	chk_pick_steady: assert property (
		!seq_change |=> ##1 $stable(pattern_pick)) else $error("pick moved");
	chk_hold_out: assert property (
		frozen && !line_start |=> $stable(v_out)) else $error("held outputs moved");
	// phase output lags the engine by one register stage
	chk_hold_phase: assert property (
		frozen && $past(frozen) && !$past(line_start)
		|=> $stable(pattern_phase)) else $error("phase moved while held");
	chk_line_clear: assert property (
		line_start |=> !frozen) else $error("hold survived line start");
	chk_busy_clear: assert property (
		line_start |=> ##1 group_busy == 4'h0) else $error("busy after line");
endmodule
bind vps_seq_regs vps_seq_regs_assertions vps_seq_regs_assertions_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .line_start(line_start), .seq_change(seq_change),
	.v_out(v_out), .seq_num(seq_num), .pattern_pick(pattern_pick),
	.pattern_phase(pattern_phase), .group_busy(group_busy), .frozen(frozen));
`default_nettype wire

/* vps_pattern_store.sv */
// stored pattern model: level per group from picked pattern and phase
`timescale 1ns/10ps
`default_nettype none
module vps_pattern_store (
	input wire logic [19:0] pattern_pick, // pattern per group
	input wire logic [51:0] pattern_phase, // phase per group
	output logic [3:0] pattern_level // level per group
);
	// odd patterns sit high, every pattern flips late in a repetition
	always_comb begin
		for (int g = 0; g < 4; g++) begin
			pattern_level[g] = pattern_pick[5*g]
				^ (pattern_phase[13*g+:13] >= 13'h001e);
		end
	end
endmodule
`default_nettype wire

/* vps_seq_regs_tb_top.sv */
// testbench for the v-sequence register block
`timescale 1ns/10ps
`default_nettype none
module vps_seq_regs_tb_top;
	logic pclk, presetn, psel, penable, pwrite, line_start, seq_change;
	logic vs, pready, pslverr, frozen, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rs, pol, lo, up, pk, d, s;
	logic [4:0] region_seq, seq_num;
	logic [3:0] pattern_level, group_busy;
	logic [23:0] v_out;
	logic [19:0] pattern_pick;
	logic [51:0] pattern_phase;
	logic [33:0] b;
	logic [53:0] o;
	logic [33:0] bq[$];
	logic [53:0] oq[$];
	int errors = 0, checked = 0, cyc = 0;
	int st[4] = '{10, 13, 15, 17};
	int rp[4] = '{11, 14, 16, 18};
	vps_seq_regs vps_seq_regs_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_start(line_start), .seq_change(seq_change),
		.region_seq(region_seq), .pattern_level(pattern_level),
		.v_out(v_out), .seq_num(seq_num), .pattern_pick(pattern_pick),
		.pattern_phase(pattern_phase), .group_busy(group_busy),
		.frozen(frozen));
	vps_pattern_store vps_pattern_store_inst (.pattern_pick(pattern_pick),
		.pattern_phase(pattern_phase), .pattern_level(pattern_level));
	// clock
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	function automatic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// writable bits of each register index
	function automatic [31:0] mk(input int i);
		case (i)
			0, 1, 8: return 32'h00ffffff;
			2: return 32'h03ffe001;
			3, 4, 5, 6, 7: return 32'h00000000;
			9: return 32'h003fffff;
			default: return 32'h03ffffff;
		endcase
	endfunction
	// outputs assigned to group g
	function automatic [23:0] gm(input int g);
		logic [47:0] a;
		a = {up[23:0], lo[23:0]};
		for (int i = 0; i < 24; i++) gm[i] = (a[2*i+:2] == g[1:0]);
	endfunction
	task automatic apb(input logic w, input int a, input [31:0] v,
		input [33:0] e);
		bq.push_back(e);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= 8'(a * 4);
		pwdata <= v;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input int a, input [31:0] v);
		apb(1, a, v, 34'h0);
	endtask
	task automatic pl(input logic c);
		@(posedge pclk);
		seq_change <= c;
		line_start <= !c;
		@(posedge pclk);
		seq_change <= 0;
		line_start <= 0;
	endtask
	task automatic vc(input int n, input [53:0] e);
		repeat (n) @(posedge pclk);
		oq.push_back(e);
		vs <= 1;
		@(posedge pclk);
		vs <= 0;
	endtask
	task automatic fail(input [63:0] got, input [63:0] exp);
		errors++;
		$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
	endtask
	task automatic end_sim();
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// compare oldest notes with bus answers and output samples
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready) begin
			b = bq.pop_front();
			checked++;
			if (pslverr !== b[32] || (b[33] && prdata !== b[31:0]))
				fail({pslverr, prdata}, b);
		end
		if (vs) begin
			o = oq.pop_front();
			checked++;
			if ({group_busy, pattern_pick, frozen, seq_num, v_out} !== o)
				fail({group_busy, pattern_pick, frozen, seq_num, v_out}, o);
		end
		if (cyc == 5000) begin
			errors++;
			end_sim();
		end
	end
	// main sequence
	initial begin
		rs = 32'h874a;
		{psel, penable, pwrite, line_start, seq_change, vs} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		region_seq = 5'h00;
		presetn = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 20; i++) begin
			er = (i > 3 && i < 8);
			d = xs();
			// status shows the hold flag: a cleared hold word matches pos 0
			s = (i == 3) ? 32'h00000200 : 32'h00000000;
			apb(0, i, 0, {1'b1, er, s});
			apb(1, i, d, {1'b0, er, 32'h0});
			apb(0, i, 0, {1'b1, er, s | (d & mk(i))});
		end
		lo = xs() & 32'hffffff;
		up = xs() & 32'hffffff;
		pol = xs() & 32'hffffff;
		wr(0, lo);
		// upper address bit set: refused, stored word left alone
		apb(1, 32, ~lo, {1'b0, 1'b1, 32'h0});
		apb(0, 0, 0, {1'b1, 1'b0, lo});
		wr(8, up);
		wr(1, pol);
		wr(2, 32'h50001);
		wr(19, 32'h1fff);
		wr(12, 0);
		for (int g = 0; g < 4; g++) wr(st[g], 32'h50002);
		for (int g = 0; g < 4; g++) begin
			pk = xs() & 32'hfffff;
			for (int h = 0; h < 4; h++) pk[5*h] = (h == g);
			wr(9, pk);
			for (int h = 0; h < 4; h++) wr(rp[h], 32'(h == g));
			pl(1);
			pl(0);
			vc(10, {4'(1 << g), pk[19:0], 6'h00, pol[23:0] ^ gm(g)});
			pl(0);
			vc(10, {4'h0, pk[19:0], 6'h00, pol[23:0]});
		end
		wr(rp[3], 0);
		pl(1);
		wr(9, 32'h100000);
		pl(0);
		vc(4, {4'h0, pk[19:0], 6'h00, pol[23:0]});
		pl(1);
		pl(0);
		pl(0);
		vc(4, {24'h000000, 1'b0, 5'h02, pol[23:0]});
		region_seq <= 5'h11;
		wr(9, 32'h300000);
		pl(1);
		pl(0);
		vc(4, {24'h000000, 1'b0, 5'h11, pol[23:0]});
		wr(9, 32'h1);
		wr(10, 32'h50000);
		wr(11, 1);
		wr(19, {6'h00, 13'h0014, 13'h0008});
		pl(1);
		pl(0);
		vc(10, {4'h1, 20'h00001, 1'b1, 5'h11, pol[23:0] ^ gm(0)});
		vc(20, {4'h1, 20'h00001, 1'b0, 5'h11, pol[23:0] ^ gm(0)});
		end_sim();
	end
endmodule
`default_nettype wire
